// ===== include/fsb_pkg.sv
// Shared constants, types and coding functions for the data-phase link
// How it works
// - Driving agent holds busy low while occupying bus
// - Nobody starts driving until busy is released
// - Non-in-order agent asserts completion_n_a toward processor
// - Addressed chipset agent drives completion_n_a, not requester
// - Four parity lines guard the 64-bit word
// - Parity driven by the agent driving data
// - Four inversion lines flag inverted 16-bit groups
// - Invert group when over half bits low
package fsb_pkg;
    localparam int DATA_W = 64;
    localparam int GROUP_W = 16;
    localparam int GROUPS = 4;
    localparam int FIFO_DEPTH = 4;
    localparam logic [4:0] INVERT_LIMIT = 5'h08;
    localparam logic [4:0] ONES_ZERO = 5'h00;

    typedef enum logic [0:0] {
        FSB_IDLE = 1'b0,
        FSB_DRIVE = 1'b1
    } fsb_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] data_n;
        logic [GROUPS-1:0] parity_n;
        logic [GROUPS-1:0] invert_n;
    } fsb_wire_t;

    typedef struct packed {
        logic [DATA_W-1:0] word;
        logic parity_error;
    } fsb_rx_t;

    // Active-low lines: a logical one is an electrically low pin
    function automatic fsb_wire_t fsb_encode(input logic [DATA_W-1:0] word);
        fsb_wire_t w;
        logic [GROUP_W-1:0] grp;
        logic [4:0] ones;
        w = '0;
        for (int g = 0; g < GROUPS; g++)
        begin
            grp = word[g*GROUP_W +: GROUP_W];
            ones = ONES_ZERO;
            for (int b = 0; b < GROUP_W; b++)
            begin
                ones = ones + 5'(grp[b]);
            end
            w.invert_n[g] = 1'b1;
            if (ones > INVERT_LIMIT)
            begin
                grp = ~grp;
                w.invert_n[g] = 1'b0;
            end
            w.data_n[g*GROUP_W +: GROUP_W] = ~grp;
            w.parity_n[g] = ~(^grp);
        end
        return w;
    endfunction

    function automatic fsb_rx_t fsb_decode(input fsb_wire_t w);
        fsb_rx_t r;
        logic [GROUP_W-1:0] grp;
        r = '0;
        for (int g = 0; g < GROUPS; g++)
        begin
            grp = ~w.data_n[g*GROUP_W +: GROUP_W];
            if ((^grp) != ~w.parity_n[g])
            begin
                r.parity_error = 1'b1;
            end
            if (!w.invert_n[g])
            begin
                grp = ~grp;
            end
            r.word[g*GROUP_W +: GROUP_W] = grp;
        end
        return r;
    endfunction
endpackage

// ===== include/fsb_link_if.sv
// Shared data-phase wires between processor and chipset ends
`timescale 1ns/100ps
interface fsb_link_if;
    logic cpu_oe;
    logic cpu_busy_n;
    fsb_pkg::fsb_wire_t cpu_wire;
    logic cs_oe;
    logic cs_busy_n;
    fsb_pkg::fsb_wire_t cs_wire;
    logic bus_request;
    logic completion_n_a;
    logic data_bus_busy_n;
    fsb_pkg::fsb_wire_t data_wire;

    // Pull-up: undriven lines float high (deasserted)
    assign data_bus_busy_n = cpu_oe ? cpu_busy_n :
                             (cs_oe ? cs_busy_n : 1'b1);
    assign data_wire = cpu_oe ? cpu_wire : (cs_oe ? cs_wire : '1);

    modport cpu (
        output cpu_oe, cpu_busy_n, cpu_wire, bus_request,
        input data_bus_busy_n, data_wire, completion_n_a
    );
    modport chipset (
        output cs_oe, cs_busy_n, cs_wire, completion_n_a,
        input data_bus_busy_n, data_wire, bus_request
    );
endinterface

// ===== verilog/fsb_cpu_end.sv
// Processor end: transmit FIFO, bus driver, receiver, completion_n_a capture
`timescale 1ns/100ps
module fsb_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] count, next_count;
    logic push, pop;

    assign in_ready = count != FULL;
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push)
        begin
            next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_count = count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// One bus driver; one word per cycle while it holds busy
module fsb_drive (
    input wire logic clock,
    input wire logic rst,
    input wire logic bus_free,
    input wire logic may_start,
    input wire logic src_valid,
    input wire logic [fsb_pkg::DATA_W-1:0] src_data,
    output logic src_ready,
    output logic oe,
    output logic busy_n,
    output fsb_pkg::fsb_wire_t wire_out
);
    fsb_pkg::fsb_state_t state, next_state;
    fsb_pkg::fsb_wire_t next_wire;

    assign oe = state == fsb_pkg::FSB_DRIVE;
    assign busy_n = !oe;

    always_comb
    begin
        next_state = state;
        next_wire = wire_out;
        src_ready = 1'b0;
        case (state)
            fsb_pkg::FSB_IDLE:
            begin
                // Start only after the other agent released busy
                if (bus_free && may_start && src_valid)
                begin
                    src_ready = 1'b1;
                    next_state = fsb_pkg::FSB_DRIVE;
                    next_wire = fsb_pkg::fsb_encode(src_data);
                end
            end
            fsb_pkg::FSB_DRIVE:
            begin
                if (src_valid)
                begin
                    src_ready = 1'b1;
                    next_wire = fsb_pkg::fsb_encode(src_data);
                end
                else
                begin
                    next_state = fsb_pkg::FSB_IDLE;
                end
            end
            default:
            begin
                next_state = fsb_pkg::FSB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= fsb_pkg::FSB_IDLE;
            wire_out <= '1;
        end
        else
        begin
            state <= next_state;
            wire_out <= next_wire;
        end
    end
endmodule

module fsb_cpu_end (
    input wire logic clock,
    input wire logic rst,
    fsb_link_if.cpu link,
    input wire logic tx_valid,
    input wire logic [fsb_pkg::DATA_W-1:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [fsb_pkg::DATA_W-1:0] rx_data,
    output logic rx_parity_error,
    output logic completion_n_a_seen
);
    logic q_valid, q_ready;
    logic [fsb_pkg::DATA_W-1:0] q_data;
    fsb_pkg::fsb_rx_t dec;
    logic rx_take;
    logic next_rx_valid, next_rx_parity_error, next_completion_n_a_seen;
    logic [fsb_pkg::DATA_W-1:0] next_rx_data;

    fsb_fifo #(
        .WIDTH(fsb_pkg::DATA_W),
        .DEPTH(fsb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(tx_valid),
        .in_data(tx_data),
        .in_ready(tx_ready),
        .out_valid(q_valid),
        .out_data(q_data),
        .out_ready(q_ready)
    );

    // Processor wins ties; chipset does not start a burst while this is high
    assign link.bus_request = q_valid;

    fsb_drive u_drive (
        .clock(clock),
        .rst(rst),
        .bus_free(link.data_bus_busy_n),
        .may_start(1'b1),
        .src_valid(q_valid),
        .src_data(q_data),
        .src_ready(q_ready),
        .oe(link.cpu_oe),
        .busy_n(link.cpu_busy_n),
        .wire_out(link.cpu_wire)
    );

    assign rx_take = !link.data_bus_busy_n && !link.cpu_oe;
    assign dec = fsb_pkg::fsb_decode(link.data_wire);

    // Data and error hold between words so a slow reader still sees them
    always_comb
    begin
        next_rx_valid = rx_take;
        next_completion_n_a_seen = !link.completion_n_a;
        next_rx_data = rx_data;
        next_rx_parity_error = rx_parity_error;
        if (rx_take)
        begin
            next_rx_data = dec.word;
            next_rx_parity_error = dec.parity_error;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rx_valid <= 1'b0;
            rx_data <= '0;
            rx_parity_error <= 1'b0;
            completion_n_a_seen <= 1'b0;
        end
        else
        begin
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            rx_parity_error <= next_rx_parity_error;
            completion_n_a_seen <= next_completion_n_a_seen;
        end
    end
endmodule

// ===== verilog/fsb_chipset_end.sv
// Chipset end: direct bus driver, receiver and completion_n_a output
`timescale 1ns/100ps
module fsb_chipset_end (
    input wire logic clock,
    input wire logic rst,
    fsb_link_if.chipset link,
    input wire logic tx_valid,
    input wire logic [fsb_pkg::DATA_W-1:0] tx_data,
    output logic tx_ready,
    input wire logic completion_n_a_req,
    output logic rx_valid,
    output logic [fsb_pkg::DATA_W-1:0] rx_data,
    output logic rx_parity_error
);
    fsb_pkg::fsb_rx_t dec;
    logic rx_take;
    logic next_rx_valid, next_rx_parity_error, next_completion_n_a;
    logic [fsb_pkg::DATA_W-1:0] next_rx_data;

    // Yield to a pending processor burst so both never start together
    fsb_drive u_drive (
        .clock(clock),
        .rst(rst),
        .bus_free(link.data_bus_busy_n),
        .may_start(!link.bus_request),
        .src_valid(tx_valid),
        .src_data(tx_data),
        .src_ready(tx_ready),
        .oe(link.cs_oe),
        .busy_n(link.cs_busy_n),
        .wire_out(link.cs_wire)
    );

    assign rx_take = !link.data_bus_busy_n && !link.cs_oe;
    assign dec = fsb_pkg::fsb_decode(link.data_wire);

    always_comb
    begin
        next_rx_valid = rx_take;
        next_completion_n_a = !completion_n_a_req;
        next_rx_data = rx_data;
        next_rx_parity_error = rx_parity_error;
        if (rx_take)
        begin
            next_rx_data = dec.word;
            next_rx_parity_error = dec.parity_error;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rx_valid <= 1'b0;
            rx_data <= '0;
            rx_parity_error <= 1'b0;
            link.completion_n_a <= 1'b1;
        end
        else
        begin
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            rx_parity_error <= next_rx_parity_error;
            link.completion_n_a <= next_completion_n_a;
        end
    end
endmodule

// ===== dv/fsb_link_monitor.sv
// Concurrent checks on the shared data-phase wires
`timescale 1ns/100ps
module fsb_link_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic cpu_oe,
    input wire logic cpu_busy_n,
    input wire logic cs_oe,
    input wire logic cs_busy_n,
    input wire logic bus_request,
    input wire logic data_bus_busy_n,
    input wire fsb_pkg::fsb_wire_t data_wire
);
    logic [15:0] grp;
    logic [3:0] par_ok;
    logic [3:0] inv_ok;
    // Even group width, so parity of the pins equals parity as sent
    always_comb
    begin
        grp = '0;
        for (int g = 0; g < 4; g++)
        begin
            grp = data_wire.data_n[g*16 +: 16];
            par_ok[g] = data_wire.parity_n[g] == ~^grp;
            inv_ok[g] = data_wire.invert_n[g] || $countones(~grp) < 8;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_cpu_busy_held: assert property (
        cpu_oe |-> !cpu_busy_n && !data_bus_busy_n)
        else $error("cpu drives without busy");
    a_cs_busy_held: assert property (
        cs_oe |-> !cs_busy_n && !data_bus_busy_n)
        else $error("chipset drives without busy");
    a_single_driver: assert property (!(cpu_oe && cs_oe))
        else $error("two drivers at once");
    a_cpu_start_free: assert property (
        $rose(cpu_oe) |-> $past(data_bus_busy_n))
        else $error("cpu started on a busy bus");
    a_cs_start_free: assert property (
        $rose(cs_oe) |-> $past(data_bus_busy_n))
        else $error("chipset started on a busy bus");
    a_request_served: assert property (
        bus_request && data_bus_busy_n |=> cpu_oe && !cs_oe)
        else $error("free bus not taken by requester");
    a_parity_group: assert property (
        !data_bus_busy_n |-> &par_ok)
        else $error("parity line wrong");
    a_invert_limit: assert property (
        !data_bus_busy_n |-> &inv_ok)
        else $error("inverted group too many lows");
endmodule

// ===== dv/testbench.sv
// Self-checking bench joining both ends of the data-phase link
`timescale 1ns/100ps
module testbench;
    logic clock = 0;
    logic rst = 1;
    logic c_tv, c_tr, c_rv, c_pe, c_ds, s_tv, s_tr, s_rv, s_pe, dreq;
    logic [63:0] c_td, c_rd, s_td, s_rd;
    logic [63:0] cq[$];
    logic [63:0] sq[$];
    logic [63:0] corner [4] = '{64'h0, 64'hffff_ffff_ffff_ffff,
        64'h00ff_01ff_fe00_ff00, 64'h8000_7fff_0001_fffe};
    int miscompares = 0;
    int n_tests = 0;
    int seed = 32'hdf44;
    int cw = 0, sw = 0, cr = 0, sr = 0, taken;
    logic h1 = 0, h2 = 0, den = 0, c_ok, s_ok;
    always #10 clock = ~clock;
    fsb_link_if link();
    fsb_cpu_end i_fsb_cpu_end (.clock(clock), .rst(rst), .link(link),
        .tx_valid(c_tv), .tx_data(c_td), .tx_ready(c_tr), .rx_valid(c_rv),
        .rx_data(c_rd), .rx_parity_error(c_pe), .completion_n_a_seen(c_ds));
    fsb_chipset_end i_fsb_chipset_end (.clock(clock), .rst(rst),
        .link(link), .tx_valid(s_tv), .tx_data(s_td), .tx_ready(s_tr),
        .completion_n_a_req(dreq), .rx_valid(s_rv), .rx_data(s_rd),
        .rx_parity_error(s_pe));
    fsb_link_monitor i_fsb_link_monitor (.clock(clock), .rst(rst),
        .cpu_oe(link.cpu_oe), .cpu_busy_n(link.cpu_busy_n),
        .cs_oe(link.cs_oe), .cs_busy_n(link.cs_busy_n),
        .bus_request(link.bus_request),
        .data_bus_busy_n(link.data_bus_busy_n), .data_wire(link.data_wire));
    task chk(input logic [71:0] seen, input logic [71:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    function automatic fsb_pkg::fsb_wire_t enc(input logic [63:0] d);
        fsb_pkg::fsb_wire_t w;
        logic [15:0] g;
        for (int i = 0; i < 4; i++)
        begin
            g = d[16*i +: 16];
            w.invert_n[i] = !($countones(g) > 8);
            if (!w.invert_n[i])
                g = ~g;
            w.data_n[16*i +: 16] = ~g;
            w.parity_n[i] = ~^g;
        end
        return w;
    endfunction
    function automatic logic [63:0] rnd64();
        return {$random(seed), $random(seed)};
    endfunction
    task step(input logic cv, input logic [63:0] cd, input logic sv,
              input logic [63:0] sd);
        @(negedge clock);
        c_tv = cv;
        c_td = cd;
        s_tv = sv;
        s_td = sd;
        #1;
        c_ok = cv && c_tr;
        s_ok = sv && s_tr;
        if (c_ok)
            cq.push_back(cd);
        if (s_ok)
            sq.push_back(sd);
        taken += int'(c_ok);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(negedge clock)
    begin
        if (!rst && link.cpu_oe)
            chk(link.data_wire, enc(cq[cw++]));
        if (!rst && link.cs_oe)
            chk(link.data_wire, enc(sq[sw++]));
        if (s_rv)
            chk({s_pe, s_rd}, {1'b0, cq[sr++]});
        if (c_rv)
            chk({c_pe, c_rd}, {1'b0, sq[cr++]});
        if (den)
        begin
            chk({c_ds, link.completion_n_a}, {h2, !h1});
            h2 = h1;
            h1 = 1'($random(seed));
            dreq = h1;
        end
    end
    initial
    begin
        logic cv, sv;
        logic [63:0] cd, sd;
        fsb_pkg::fsb_wire_t wv;
        fsb_pkg::fsb_rx_t rv;
        cv = 0;
        sv = 0;
        c_tv = 0;
        s_tv = 0;
        c_td = 64'h0;
        s_td = 64'h0;
        dreq = 0;
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 0;
        den = 1;
        taken = 0;
        // Chipset holds the bus, so the processor queue must fill and refuse
        for (int i = 0; i < 8; i++)
            step(1'b1, corner[i % 4], 1'b1, rnd64());
        chk(taken, fsb_pkg::FIFO_DEPTH);
        $display("fill test done");
        repeat (12) step(0, 64'h0, 0, 64'h0);
        for (int i = 0; i < 400; i++)
        begin
            if (c_ok || !cv)
            begin
                cv = 1'($random(seed));
                cd = rnd64();
            end
            if (s_ok || !sv)
            begin
                sv = 1'($random(seed));
                sd = rnd64();
            end
            step(cv, cd, sv, sd);
        end
        $display("random test done");
        // Receivers never see a bad word on the link, so flip a line here
        foreach (corner[i])
        begin
            wv = enc(corner[i]);
            rv = fsb_pkg::fsb_decode(wv);
            chk(rv, {corner[i], 1'b0});
            wv.data_n[16*i] = ~wv.data_n[16*i];
            rv = fsb_pkg::fsb_decode(wv);
            chk(rv.parity_error, 1'b1);
        end
        $display("parity test done");
        repeat (12) step(0, 64'h0, 0, 64'h0);
        chk(sr, cq.size());
        chk(cr, sq.size());
        report_and_stop;
    end
    // About 450 cycles of work; a wide margin before calling it a hang
    initial
    begin
        repeat (3000) @(posedge clock);
        miscompares++;
        report_and_stop;
    end
endmodule
